// ===== design/link_timing_pkg.sv
// Package: timing constants, codes and states for the link timing controller
package link_timing_pkg;
  // Controller clock
  localparam int CLK_HZ = 25000000;
  // Printed times, in their own units
  localparam int IDLE_REVERT_US = 3000;
  localparam int IDLE_REVERT_LATE_US = 3125;
  localparam int SAMPLE_MIN_US = 100;
  localparam int SAMPLE_MAX_US = 875;
  localparam int RESUME_MIN_US = 5000;
  localparam int SUSPEND_MAX_US = 10000;
  localparam int FS_RESET_NS = 2500;
  localparam int NO_CHIRP_MIN_US = 1000;
  localparam int NO_CHIRP_MAX_US = 2500;
  localparam int CHIRP_PHY_CYCLES = 66000;
  localparam int UNENC_LEAD_PHY_CYCLES = 5;
  // Cycle counts at the controller rate; least times round up
  localparam int IDLE_REVERT_CYC = (IDLE_REVERT_US * (CLK_HZ / 1000000)) + 1;
  localparam int SAMPLE_CYC = ((SAMPLE_MIN_US + SAMPLE_MAX_US) / 2) * (CLK_HZ / 1000000);
  localparam int RESUME_MIN_CYC = RESUME_MIN_US * (CLK_HZ / 1000000);
  localparam int FS_RESET_CYC = (FS_RESET_NS * (CLK_HZ / 1000000) + 999) / 1000 + 1;
  localparam int NO_CHIRP_CYC = ((NO_CHIRP_MIN_US + NO_CHIRP_MAX_US) / 2) * (CLK_HZ / 1000000);
  // Line state codes
  localparam logic [1:0] LS_SE0 = 2'h0;
  localparam logic [1:0] LS_J = 2'h1;
  localparam logic [1:0] LS_K = 2'h2;
  // Operating mode codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_UNENCODED = 2'h2;
  // Speed and termination select: 1 is full speed
  localparam logic SEL_FS = 1'b1;
  localparam logic SEL_HS = 1'b0;
  // Controller states
  typedef enum logic [2:0] {
    ST_HS_ACTIVE = 3'b000,
    ST_FS_REVERT = 3'b001,
    ST_SUSPEND = 3'b010,
    ST_FS_ACTIVE = 3'b011,
    ST_MODE_LEAD = 3'b100,
    ST_CHIRP = 3'b101,
    ST_WAIT_HOST = 3'b110,
    ST_WAIT_END = 3'b111
  } link_state_e;
endpackage : link_timing_pkg

// ===== design/level_sync.sv
// Module: two-stage synchroniser for a bus of levels
`timescale 1ns/1ns
`default_nettype none
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage_a_ff;
  logic [WIDTH-1:0] stage_b_ff;
  logic [WIDTH-1:0] nxt_stage_a;
  logic [WIDTH-1:0] nxt_stage_b;
  // First stage is read only by the second
  always_comb begin
    nxt_stage_a = async_in;
    nxt_stage_b = stage_a_ff;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage_a_ff <= '0;
      stage_b_ff <= '0;
    end else begin
      stage_a_ff <= nxt_stage_a;
      stage_b_ff <= nxt_stage_b;
    end
  end
  assign sync_out = stage_b_ff;
endmodule : level_sync
`default_nettype wire

// ===== design/phy_clk_counter.sv
// Module: counts rising edges of the sampled transceiver clock
`timescale 1ns/1ns
`default_nettype none
module phy_clk_counter #(
  parameter int WIDTH = 17
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic phy_clk_sync,
  input wire logic clear,
  output logic [WIDTH-1:0] count,
  output logic edge_seen
);
  logic last_ff;
  logic nxt_last;
  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] nxt_count;
  // Edge found by comparing the synchronised level with its last value
  always_comb begin
    nxt_last = phy_clk_sync;
    edge_seen = phy_clk_sync & ~last_ff;
    if (clear) begin
      nxt_count = '0;
    end else if (edge_seen && (count_ff != '1)) begin
      nxt_count = count_ff + 1'b1;
    end else begin
      nxt_count = count_ff;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_ff <= 1'b0;
      count_ff <= '0;
    end else begin
      last_ff <= nxt_last;
      count_ff <= nxt_count;
    end
  end
  assign count = count_ff;
endmodule : phy_clk_counter
`default_nettype wire

// ===== design/link_timing_ctrl.sv
// Module: suspend, reset and chirp timing controller driving the transceiver selects
// What this block does
// - Idle SE0 over 3 ms: revert full speed
// - Revert between 3.0 and 3.125 ms
// - Sample line once 100 to 875 us later
// - Sample J means suspend
// - Fully suspended within 10 ms
// - Sample SE0 means reset, start handshake
// - No resume before 5 ms idle
// - Suspended: SE0 starts handshake immediately
// - Full speed: SE0 over 2.5 us starts handshake
// - From suspend: 1 ms chirp within 6 ms
// - Handshake: unencoded mode, high speed, zeros
// - Chirp at least 1 ms, ends by 7 ms
// - Chirp begins before 6 ms
// - Chirp held 66000 transceiver clocks
// - No host chirps: back to full speed
// - Capable host chirps within 100 us
// - Host holds reset at least 10 ms
// - Handshake start 0 to 4 ms late
// - Transmit valid five clocks after mode
`timescale 1ns/1ns
`default_nettype none
module link_timing_ctrl
  import link_timing_pkg::*;
#(
  parameter int IDLE_CYC = IDLE_REVERT_CYC,
  parameter int SMP_CYC = SAMPLE_CYC,
  parameter int RESUME_CYC = RESUME_MIN_CYC,
  parameter int HOST_WAIT_CYC = NO_CHIRP_CYC,
  parameter int CHIRP_CYC = CHIRP_PHY_CYCLES,
  parameter int LEAD_CYC = UNENC_LEAD_PHY_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  // Transceiver side
  input wire logic phy_output_clock,
  input wire logic [1:0] line_state,
  output logic transceiver_speed_select,
  output logic termination_select,
  output logic [1:0] operating_mode_select,
  output logic suspend_active_low,
  output logic transmit_valid,
  output logic [7:0] transmit_data,
  // User side
  input wire logic start_hs,
  input wire logic resume_req,
  input wire logic host_chirp_seen,
  input wire logic reset_end,
  output logic suspended,
  output logic resume_allowed,
  output logic hs_handshake_fail,
  output logic hs_chirp_done
);
  localparam int CW = 24;
  localparam int PW = 17;
  logic [1:0] ls_sync;
  logic phy_clk_sync;
  logic [PW-1:0] phy_count;
  logic phy_edge;
  logic phy_clear;
  link_state_e state_ff;
  link_state_e nxt_state;
  logic [CW-1:0] timer_ff;
  logic [CW-1:0] nxt_timer;
  logic [CW-1:0] idle_ff;
  logic [CW-1:0] nxt_idle;
  logic xs_ff, nxt_xs;
  logic ts_ff, nxt_ts;
  logic [1:0] mode_ff, nxt_mode;
  logic susp_n_ff, nxt_susp_n;
  logic txv_ff, nxt_txv;
  logic fail_ff, nxt_fail;
  logic done_ff, nxt_done;
  logic from_susp_ff, nxt_from_susp;
  logic [1:0] ls_last_ff;
  logic ls_change;

  // Transceiver inputs pass two flops before any logic; user side inputs are used directly
  level_sync #(.WIDTH(3)) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({phy_output_clock, line_state}),
    .sync_out({phy_clk_sync, ls_sync})
  );

  // Transceiver clock edges time the chirp and the mode lead
  phy_clk_counter #(.WIDTH(PW)) u_phy_cnt (
    .clk(clk),
    .rst(rst),
    .phy_clk_sync(phy_clk_sync),
    .clear(phy_clear),
    .count(phy_count),
    .edge_seen(phy_edge)
  );

  // Idle time counts an unchanged SE0 line, or any unchanged line while suspended
  assign ls_change = (ls_sync != ls_last_ff);
  always_comb begin
    nxt_idle = idle_ff;
    if (ls_change || (ls_sync != LS_SE0 && state_ff != ST_SUSPEND)) begin
      nxt_idle = '0;
    end else if (idle_ff != '1) begin
      nxt_idle = idle_ff + 1'b1;
    end
  end

  // Main state machine; selects are registered so the pins never glitch
  always_comb begin
    nxt_state = state_ff;
    nxt_timer = (timer_ff != '1) ? timer_ff + 1'b1 : timer_ff;
    nxt_xs = xs_ff;
    nxt_ts = ts_ff;
    nxt_mode = mode_ff;
    nxt_susp_n = susp_n_ff;
    nxt_txv = txv_ff;
    nxt_fail = 1'b0;
    nxt_done = 1'b0;
    nxt_from_susp = from_susp_ff;
    phy_clear = 1'b0;
    case (state_ff)
      ST_HS_ACTIVE: begin
        if (idle_ff >= CW'(IDLE_CYC)) begin
          // Revert just past 3.0 ms, well before 3.125 ms
          nxt_xs = SEL_FS;
          nxt_ts = SEL_FS;
          nxt_timer = '0;
          nxt_state = ST_FS_REVERT;
        end
      end
      ST_FS_REVERT: begin
        // One sample mid-window
        if (timer_ff == CW'(SMP_CYC)) begin
          if (ls_sync == LS_J) begin
            nxt_susp_n = 1'b0;
            nxt_state = ST_SUSPEND;
          end else if (ls_sync == LS_SE0) begin
            nxt_from_susp = 1'b0;
            nxt_timer = '0;
            phy_clear = 1'b1;
            nxt_mode = MODE_UNENCODED;
            nxt_xs = SEL_HS;
            nxt_state = ST_MODE_LEAD;
          end else begin
            nxt_state = ST_FS_ACTIVE;
          end
        end
      end
      ST_SUSPEND: begin
        if (ls_sync == LS_SE0) begin
          // Wake at once; clock returns inside the 6 ms budget
          nxt_susp_n = 1'b1;
          nxt_from_susp = 1'b1;
          nxt_timer = '0;
          phy_clear = 1'b1;
          nxt_mode = MODE_UNENCODED;
          nxt_xs = SEL_HS;
          nxt_state = ST_MODE_LEAD;
        end else if (resume_req && idle_ff >= CW'(RESUME_CYC)) begin
          nxt_susp_n = 1'b1;
          nxt_state = ST_FS_ACTIVE;
        end
      end
      ST_FS_ACTIVE: begin
        if (ls_sync == LS_SE0 && idle_ff >= CW'(FS_RESET_CYC)) begin
          nxt_timer = '0;
          phy_clear = 1'b1;
          nxt_mode = MODE_UNENCODED;
          nxt_xs = SEL_HS;
          nxt_state = ST_MODE_LEAD;
        end else if (start_hs) begin
          nxt_xs = SEL_HS;
          nxt_ts = SEL_HS;
          nxt_state = ST_HS_ACTIVE;
        end
      end
      ST_MODE_LEAD: begin
        // Mode settles before transmit valid rises
        if (phy_count >= PW'(LEAD_CYC)) begin
          nxt_txv = 1'b1;
          phy_clear = 1'b1;
          nxt_state = ST_CHIRP;
        end
      end
      ST_CHIRP: begin
        if (phy_count >= PW'(CHIRP_CYC)) begin
          nxt_txv = 1'b0;
          nxt_mode = MODE_NORMAL;
          nxt_done = 1'b1;
          nxt_timer = '0;
          nxt_state = ST_WAIT_HOST;
        end
      end
      ST_WAIT_HOST: begin
        if (host_chirp_seen) begin
          nxt_ts = SEL_HS;
          nxt_state = ST_WAIT_END;
        end else if (timer_ff >= CW'(HOST_WAIT_CYC)) begin
          nxt_xs = SEL_FS;
          nxt_fail = 1'b1;
          nxt_state = ST_WAIT_END;
        end
      end
      ST_WAIT_END: begin
        // Host holds reset at least 10 ms
        if (reset_end) begin
          nxt_state = (xs_ff == SEL_HS) ? ST_HS_ACTIVE : ST_FS_ACTIVE;
        end
      end
      default: begin
        nxt_state = ST_FS_ACTIVE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_FS_ACTIVE;
      timer_ff <= '0;
      idle_ff <= '0;
      xs_ff <= SEL_FS;
      ts_ff <= SEL_FS;
      mode_ff <= MODE_NORMAL;
      susp_n_ff <= 1'b1;
      txv_ff <= 1'b0;
      fail_ff <= 1'b0;
      done_ff <= 1'b0;
      from_susp_ff <= 1'b0;
      ls_last_ff <= LS_J;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
      idle_ff <= nxt_idle;
      xs_ff <= nxt_xs;
      ts_ff <= nxt_ts;
      mode_ff <= nxt_mode;
      susp_n_ff <= nxt_susp_n;
      txv_ff <= nxt_txv;
      fail_ff <= nxt_fail;
      done_ff <= nxt_done;
      from_susp_ff <= nxt_from_susp;
      ls_last_ff <= ls_sync;
    end
  end

  assign transceiver_speed_select = xs_ff;
  assign termination_select = ts_ff;
  assign operating_mode_select = mode_ff;
  assign suspend_active_low = susp_n_ff;
  assign transmit_valid = txv_ff;
  assign transmit_data = 8'h00; // All zeros gives chirp K
  assign suspended = (state_ff == ST_SUSPEND);
  assign resume_allowed = (state_ff == ST_SUSPEND) && (idle_ff >= CW'(RESUME_CYC));
  assign hs_handshake_fail = fail_ff;
  assign hs_chirp_done = done_ff;

  chk_revert_both_fs: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_HS_ACTIVE && nxt_state == ST_FS_REVERT) |=> (xs_ff == SEL_FS && ts_ff == SEL_FS))
    else $error("revert did not set both selects full speed");
  chk_revert_time: assert property (@(posedge clk) disable iff (rst)
    $rose(state_ff == ST_FS_REVERT) |-> (idle_ff >= CW'(IDLE_CYC)))
    else $error("revert before idle time");
  chk_j_suspends: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_FS_REVERT && timer_ff == CW'(SMP_CYC) && ls_sync == LS_J) |=> (suspended && !susp_n_ff))
    else $error("J sample did not suspend");
  chk_se0_resets: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_FS_REVERT && timer_ff == CW'(SMP_CYC) && ls_sync == LS_SE0) |=> (state_ff == ST_MODE_LEAD))
    else $error("SE0 sample did not start handshake");
  chk_resume_late: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_SUSPEND && nxt_state == ST_FS_ACTIVE) |-> (idle_ff >= CW'(RESUME_CYC)))
    else $error("resume too early");
  chk_susp_wake: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_SUSPEND && ls_sync == LS_SE0) |=> (susp_n_ff && state_ff == ST_MODE_LEAD))
    else $error("suspend SE0 did not wake");
  chk_chirp_mode: assert property (@(posedge clk) disable iff (rst)
    txv_ff |-> (mode_ff == MODE_UNENCODED && xs_ff == SEL_HS))
    else $error("chirp without unencoded high speed");
  chk_txv_lead: assert property (@(posedge clk) disable iff (rst)
    $rose(txv_ff) |-> ($past(phy_count) >= PW'(LEAD_CYC)))
    else $error("transmit valid before mode lead");
  chk_chirp_len: assert property (@(posedge clk) disable iff (rst)
    $fell(txv_ff) |-> ($past(phy_count) >= PW'(CHIRP_CYC)))
    else $error("chirp shorter than required");
  chk_no_chirp_fs: assert property (@(posedge clk) disable iff (rst)
    $rose(fail_ff) |-> (xs_ff == SEL_FS))
    else $error("failed handshake left high speed");
  chk_sample_bound: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_FS_REVERT) |-> (timer_ff <= CW'(SMP_CYC)))
    else $error("line sample missed its window");
  chk_fs_reset_len: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_FS_ACTIVE && nxt_state == ST_MODE_LEAD) |-> (idle_ff >= CW'(FS_RESET_CYC)))
    else $error("full speed reset taken too soon");
  chk_host_wait: assert property (@(posedge clk) disable iff (rst)
    (state_ff == ST_WAIT_HOST) |-> (timer_ff <= CW'(HOST_WAIT_CYC)))
    else $error("host chirp wait overran");
  chk_wake_awake: assert property (@(posedge clk) disable iff (rst)
    (from_susp_ff && (state_ff == ST_MODE_LEAD || state_ff == ST_CHIRP)) |-> susp_n_ff)
    else $error("chirp from suspend with transceiver asleep");
  chk_count_edges: assert property (@(posedge clk) disable iff (rst)
    (!phy_edge && !phy_clear) |=> (phy_count == $past(phy_count)))
    else $error("transceiver clock count moved without an edge");
endmodule : link_timing_ctrl
`default_nettype wire

// ===== test/phy_model.sv
// Transceiver model: line state and output clock seen by the controller
`timescale 1ns/1ns
`default_nettype none
module phy_model
  import link_timing_pkg::*;
(
  input wire logic [1:0] host_mode,
  input wire logic termination_select,
  input wire logic [1:0] operating_mode_select,
  input wire logic suspend_active_low,
  input wire logic transmit_valid,
  input wire logic [7:0] transmit_data,
  output logic [1:0] line_state,
  output logic phy_output_clock
);
  // Oscillator stands still in suspend; odd start keeps it off the clk edges
  initial begin
    phy_output_clock = 1'b0;
    #7;
    forever #160 phy_output_clock = suspend_active_low ? ~phy_output_clock : 1'b0;
  end
  // Host mode: 0 released, 1 driven SE0, 2 J activity
  always_comb begin
    if (transmit_valid && operating_mode_select == MODE_UNENCODED) begin
      line_state = (transmit_data == 8'h00) ? LS_K : LS_J;
    end else if (host_mode == 2'h2) begin
      line_state = LS_J;
    end else if (host_mode == 2'h1) begin
      line_state = LS_SE0;
    end else begin
      line_state = (termination_select == SEL_FS) ? LS_J : LS_SE0;
    end
  end
endmodule : phy_model
`default_nettype wire

// ===== test/tb.sv
// Testbench: suspend, reset and chirp timing of the link controller
`timescale 1ns/1ns
`default_nettype none
module tb
  import link_timing_pkg::*;
;
  // Short counts keep the run brief
  localparam int IDLE = 50;
  localparam int SMP = 20;
  localparam int RES = 100;
  localparam int HW = 60;
  localparam int CH = 30;
  localparam int LD = 5;
  logic clk, rst, phy_clk, xs, ts, sus_n, txv, start_hs, resume_req, host_chirp_seen, reset_end;
  logic suspended, resume_allowed, hs_fail, hs_done, is_unenc;
  logic [1:0] ls, mode, host_mode;
  logic [7:0] txd;
  int cyc, n_mismatch, compares, t0, t1, t2;
  assign is_unenc = (mode == MODE_UNENCODED);
  link_timing_ctrl #(.IDLE_CYC(IDLE), .SMP_CYC(SMP), .RESUME_CYC(RES), .HOST_WAIT_CYC(HW),
    .CHIRP_CYC(CH), .LEAD_CYC(LD)) i_dut (.clk(clk), .rst(rst), .phy_output_clock(phy_clk),
    .line_state(ls), .transceiver_speed_select(xs), .termination_select(ts), .operating_mode_select(mode),
    .suspend_active_low(sus_n), .transmit_valid(txv), .transmit_data(txd), .start_hs(start_hs),
    .resume_req(resume_req), .host_chirp_seen(host_chirp_seen), .reset_end(reset_end),
    .suspended(suspended), .resume_allowed(resume_allowed), .hs_handshake_fail(hs_fail),
    .hs_chirp_done(hs_done));
  phy_model i_phy (.host_mode(host_mode), .termination_select(ts), .operating_mode_select(mode),
    .suspend_active_low(sus_n), .transmit_valid(txv), .transmit_data(txd), .line_state(ls),
    .phy_output_clock(phy_clk));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;
  // Inputs move 2 ns after the edge so outputs are settled
  task step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : step
  task test_done;
    $display("counts: compares=%0d mismatches=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    compares++;
    if (got !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask : check
  task automatic check_rng(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h..%h", $time, got, lo, hi);
    end
  endtask : check_rng
  // Bounded wait; a run-out ends the run as a mismatch
  task automatic wait_sig(ref logic s, input logic v, input int lim, output int t);
    int i;
    i = 0;
    while (s !== v && i < lim) begin
      step(1);
      i++;
    end
    if (s !== v) begin
      n_mismatch++;
      $display("unexpected at %0t: timeout got %h want %h", $time, s, v);
      test_done();
    end
    t = cyc;
  endtask : wait_sig
  task test_reset_hs;
    check(xs, SEL_FS);
    check(ts, SEL_FS);
    check(mode, MODE_NORMAL);
    check(sus_n, 1'b1);
    check(txv, 1'b0);
    start_hs = 1'b1;
    step(1);
    start_hs = 1'b0;
    wait_sig(xs, SEL_HS, 5, t1);
    check(ts, SEL_HS);
    $display("test reset_hs done");
  endtask : test_reset_hs
  task test_suspend;
    host_mode = 2'h0;
    t0 = cyc;
    wait_sig(xs, SEL_FS, IDLE + 20, t1);
    check_rng(t1 - t0, IDLE, IDLE + 6);
    check(ts, SEL_FS);
    check(ls, LS_J);
    resume_req = 1'b1;
    wait_sig(suspended, 1'b1, SMP + 20, t2);
    check_rng(t2 - t1, SMP, SMP + 6);
    // Idle restarts at suspend entry, since a J line holds it at zero until the suspend state
    t1 = t2;
    check(sus_n, 1'b0);
    step(8);
    check(suspended, 1'b1);
    check(resume_allowed, 1'b0);
    resume_req = 1'b0;
    wait_sig(resume_allowed, 1'b1, RES + 20, t2);
    check_rng(t2 - t1, RES, RES + 4);
    // Resume is taken once allowed, then the link goes back to high speed and sleeps again
    resume_req = 1'b1;
    step(1);
    resume_req = 1'b0;
    check(suspended, 1'b0);
    check(sus_n, 1'b1);
    start_hs = 1'b1;
    step(1);
    start_hs = 1'b0;
    wait_sig(suspended, 1'b1, IDLE + SMP + 40, t2);
    check(ts, SEL_FS);
    check(sus_n, 1'b0);
    $display("test suspend done");
  endtask : test_suspend
  // Shared chirp walk: lead, K level, length, done pulse
  task chirp(input int ts0);
    check(xs, SEL_HS);
    check(txd, 8'h00);
    wait_sig(txv, 1'b1, (LD + 3) * 8, t2);
    check_rng(t2 - t1, (LD - 1) * 8, (LD + 2) * 8);
    check_rng(t2 - ts0, 0, (LD + 2) * 8 + IDLE + SMP + 70);
    check(ls, LS_K);
    wait_sig(hs_done, 1'b1, (CH + 3) * 8, t1);
    check_rng(t1 - t2, (CH - 1) * 8, (CH + 1) * 8 + 4);
    check(txv, 1'b0);
    check(mode, MODE_NORMAL);
  endtask : chirp
  task end_reset;
    host_mode = 2'h2;
    reset_end = 1'b1;
    step(1);
    reset_end = 1'b0;
    step(3);
  endtask : end_reset
  task test_wake;
    host_mode = 2'h1;
    t0 = cyc;
    wait_sig(is_unenc, 1'b1, 8, t1);
    check_rng(t1 - t0, 0, 5);
    check(sus_n, 1'b1);
    chirp(t0);
    wait_sig(hs_fail, 1'b1, HW + 10, t2);
    check_rng(t2 - t1, HW, HW + 4);
    step(1);
    check(xs, SEL_FS);
    end_reset();
    check(xs, SEL_FS);
    $display("test wake done");
  endtask : test_wake
  task test_fs_reset;
    host_mode = 2'h1;
    t0 = cyc;
    step(40);
    check(is_unenc, 1'b0);
    wait_sig(is_unenc, 1'b1, 40, t1);
    check_rng(t1 - t0, 64, 72);
    chirp(t0);
    host_chirp_seen = 1'b1;
    step(1);
    host_chirp_seen = 1'b0;
    wait_sig(ts, SEL_HS, 5, t2);
    check(xs, SEL_HS);
    end_reset();
    check(xs, SEL_HS);
    $display("test fs_reset done");
  endtask : test_fs_reset
  task test_hs_reset;
    host_mode = 2'h1;
    t0 = cyc;
    wait_sig(xs, SEL_FS, IDLE + 20, t1);
    wait_sig(is_unenc, 1'b1, SMP + 20, t2);
    check_rng(t2 - t1, SMP, SMP + 6);
    check(suspended, 1'b0);
    t1 = t2;
    chirp(t0);
    $display("test hs_reset done");
  endtask : test_hs_reset
  initial begin
    rst = 1'b1;
    host_mode = 2'h2;
    start_hs = 1'b0;
    resume_req = 1'b0;
    host_chirp_seen = 1'b0;
    reset_end = 1'b0;
    n_mismatch = 0;
    compares = 0;
    step(2);
    rst = 1'b0;
    step(2);
    test_reset_hs();
    test_suspend();
    test_wake();
    test_fs_reset();
    test_hs_reset();
    test_done();
  end
endmodule : tb
`default_nettype wire
